// ==== include/ersw_pkg.sv ====
// Constants and types for the error record select window block
package ersw_pkg;
  // ----------------------------------------------------------------
  // Record storage
  // ----------------------------------------------------------------
  localparam logic [15:0] REC_NUM    = 16'h0006;
  localparam int          MEM_DEPTH  = 8;
  localparam int          IDX_W      = 3;
  localparam int          DATA_W     = 32;
  localparam int          FIELD_LSB  = 0;
  localparam int          FIELD_W    = 16;
  localparam logic [15:0] SEL_RESET  = 16'h0000;
  // Select is kept (not RAZ/WI) while the record count is non-zero
  localparam logic        SEL_RAZ_WHEN_EMPTY = 1'b1;

  // ----------------------------------------------------------------
  // Coprocessor encodings (p15, opc1, CRn, CRm, opc2)
  // ----------------------------------------------------------------
  localparam logic [3:0] CP_NUM      = 4'hF;
  localparam logic [2:0] OPC1_ERR    = 3'h0;
  localparam logic [3:0] CRN_ERR     = 4'h5;
  localparam logic [3:0] CRM_GLOBAL  = 4'h3;
  localparam logic [3:0] CRM_WINDOW  = 4'h4;
  localparam logic [2:0] OPC2_COUNT  = 3'h0;
  localparam logic [2:0] OPC2_SELECT = 3'h1;
  localparam logic [2:0] OPC2_CTL_LO = 3'h1;
  localparam logic [2:0] OPC2_ADR_LO = 3'h3;
  localparam logic [2:0] OPC2_ADR_HI = 3'h7;

  // ----------------------------------------------------------------
  // Privilege levels and access outcomes
  // ----------------------------------------------------------------
  localparam logic [1:0] LVL_APP    = 2'h0;
  localparam logic [1:0] LVL_KERNEL = 2'h1;
  localparam logic [1:0] LVL_HYP    = 2'h2;
  localparam logic [1:0] LVL_MON    = 2'h3;

  localparam logic [2:0] FLT_NONE     = 3'h0;
  localparam logic [2:0] FLT_UNDEF    = 3'h1;
  localparam logic [2:0] FLT_TRAP_HYP = 3'h2;
  localparam logic [2:0] FLT_HYP_EXC  = 3'h3;
  localparam logic [2:0] FLT_TRAP_MON = 3'h4;
  localparam logic [2:0] FLT_MON_EXC  = 3'h5;

  typedef enum logic [2:0] {
    REG_NONE,
    REG_COUNT,
    REG_SELECT,
    REG_ADR_LO,
    REG_ADR_HI,
    REG_CTL_LO
  } ersw_reg_t;
endpackage

// ==== hdl/ersw_mem.sv ====
// Small record field memory with registered read data
`timescale 1ns/100ps
module ersw_mem
  import ersw_pkg::*;
#(
  parameter int W     = 32,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [W-1:0]  wdata,
  output logic      [W-1:0]  rdata_q
);
  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] rdata_d;

  // Read of the addressed word; write lands on the same edge
  always_comb begin
    rdata_d = mem_q[addr];
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end
endmodule

// ==== hdl/ersw_top.sv ====
// Error record select window: count, select and windowed record registers
//
// Overview of operation
// - Count field bits 15:0 return highest reachable record index plus one.
// - Count register is 32-bit, read-only, reached by read at p15,0,c5,c3,0.
// - Select register is 32-bit read/write at p15,0,c5,c3,1.
// - Select bits 15:0 choose the record that every window access reaches.
// - Index at or above count reads unknown; windows take one allowed outcome.
// - With zero records the select register behaviour is a fixed design choice.
// - Low address window, read/write at p15,0,c5,c4,3, maps address bits 31:0.
// - High address window, read/write at p15,0,c5,c4,7, maps address bits 63:32.
// - Low control window maps selected record control bits 31:0.
// - Any access from application level is an undefined instruction.
// - Wide hypervisor trap bits set: non-secure kernel accesses trap to hypervisor.
// - Narrow hypervisor trap bits set: non-secure kernel accesses raise hypervisor trap.
// - Wide monitor trap bit set: hypervisor and kernel accesses trap to monitor.
// - Narrow monitor trap bit set: kernel and hypervisor accesses raise monitor trap.
// - One copy of each register, shared by secure and non-secure states.
// - Wide top level shares select storage with the wide-state select register.
// - Without the reliability extension every access is undefined.
// - Low control window is read/write at p15,0,c5,c4,1.
`timescale 1ns/100ps
module ersw_top
  import ersw_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               req_valid,
  input  wire logic               req_write,
  input  wire logic [3:0]         req_cp,
  input  wire logic [2:0]         req_opc1,
  input  wire logic [3:0]         req_crn,
  input  wire logic [3:0]         req_crm,
  input  wire logic [2:0]         req_opc2,
  input  wire logic [DATA_W-1:0]  req_wdata,
  input  wire logic [1:0]         cur_level,
  input  wire logic               cur_secure,
  input  wire logic               ras_present,
  input  wire logic               hyp_present,
  input  wire logic               hyp_wide,
  input  wire logic               hyp_err_trap,
  input  wire logic               hyp_cp_group_trap,
  input  wire logic               mon_present,
  input  wire logic               mon_wide,
  input  wire logic               mon_err_trap,
  input  wire logic               wide_sel_we,
  input  wire logic [15:0]        wide_sel_wdata,
  output logic                    resp_valid_q,
  output logic [DATA_W-1:0]       resp_rdata_q,
  output logic [2:0]              resp_fault_q,
  output logic [15:0]             select_q
);
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  ersw_reg_t          dec_reg;
  logic               in_range;
  logic [2:0]         fault;
  logic               acc_ok;
  logic               win_we;
  logic [15:0]        select_d;
  logic [IDX_W-1:0]   mem_idx;
  logic [DATA_W-1:0]  adr_lo_rd;
  logic [DATA_W-1:0]  adr_hi_rd;
  logic [DATA_W-1:0]  ctl_lo_rd;

  always_comb begin
    dec_reg = REG_NONE;
    if (req_cp == CP_NUM && req_opc1 == OPC1_ERR && req_crn == CRN_ERR) begin
      if (req_crm == CRM_GLOBAL) begin
        if (req_opc2 == OPC2_COUNT) begin
          dec_reg = REG_COUNT;
        end else if (req_opc2 == OPC2_SELECT) begin
          dec_reg = REG_SELECT;
        end
      end else if (req_crm == CRM_WINDOW) begin
        if (req_opc2 == OPC2_ADR_LO) begin
          dec_reg = REG_ADR_LO;
        end else if (req_opc2 == OPC2_ADR_HI) begin
          dec_reg = REG_ADR_HI;
        end else if (req_opc2 == OPC2_CTL_LO) begin
          dec_reg = REG_CTL_LO;
        end
      end
    end
  end

  // Out of range covers the empty case, since no index is below zero
  assign in_range = (select_q < REC_NUM);

  // ----------------------------------------------------------------
  // Privilege checks and trap routing
  // ----------------------------------------------------------------
  // Secure state is ignored for storage: one copy serves both states
  always_comb begin
    fault = FLT_NONE;
    if (!ras_present || dec_reg == REG_NONE) begin
      fault = FLT_UNDEF;
    end else if (cur_level == LVL_APP) begin
      fault = FLT_UNDEF;
    end else if (dec_reg == REG_COUNT && req_write) begin
      fault = FLT_UNDEF;
    end else if (hyp_present && cur_level == LVL_KERNEL && !cur_secure
                 && (hyp_err_trap || hyp_cp_group_trap)) begin
      fault = hyp_wide ? FLT_TRAP_HYP : FLT_HYP_EXC;
    end else if (mon_present && mon_err_trap && mon_wide
                 && (cur_level == LVL_KERNEL || cur_level == LVL_HYP)) begin
      fault = FLT_TRAP_MON;
    end else if (mon_present && mon_err_trap && !mon_wide && cur_level != LVL_MON) begin
      fault = FLT_MON_EXC;
    end
  end

  assign acc_ok = req_valid && (fault == FLT_NONE);

  // ----------------------------------------------------------------
  // Select register
  // ----------------------------------------------------------------
  always_comb begin
    select_d = select_q;
    if (acc_ok && req_write && dec_reg == REG_SELECT) begin
      select_d = req_wdata[FIELD_W-1:FIELD_LSB];
    end else if (wide_sel_we) begin
      select_d = wide_sel_wdata;
    end
    if (SEL_RAZ_WHEN_EMPTY && REC_NUM == 16'h0000) begin
      select_d = 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      select_q <= SEL_RESET;
    end else begin
      select_q <= select_d;
    end
  end

  // ----------------------------------------------------------------
  // Record storage
  // ----------------------------------------------------------------
  // Out-of-range windows read zero and drop writes
  assign win_we  = acc_ok && req_write && in_range;
  assign mem_idx = select_q[IDX_W-1:0];

  ersw_mem #(.W(DATA_W), .DEPTH(MEM_DEPTH), .AW(IDX_W)) u_adr_lo (
    .clk     (clk),
    .rst_n   (rst_n),
    .we      (win_we && dec_reg == REG_ADR_LO),
    .addr    (mem_idx),
    .wdata   (req_wdata),
    .rdata_q (adr_lo_rd)
  );

  ersw_mem #(.W(DATA_W), .DEPTH(MEM_DEPTH), .AW(IDX_W)) u_adr_hi (
    .clk     (clk),
    .rst_n   (rst_n),
    .we      (win_we && dec_reg == REG_ADR_HI),
    .addr    (mem_idx),
    .wdata   (req_wdata),
    .rdata_q (adr_hi_rd)
  );

  ersw_mem #(.W(DATA_W), .DEPTH(MEM_DEPTH), .AW(IDX_W)) u_ctl_lo (
    .clk     (clk),
    .rst_n   (rst_n),
    .we      (win_we && dec_reg == REG_CTL_LO),
    .addr    (mem_idx),
    .wdata   (req_wdata),
    .rdata_q (ctl_lo_rd)
  );

  // ----------------------------------------------------------------
  // Response pipeline
  // ----------------------------------------------------------------
  // Two stages so the answer leaves straight from flops after the memory read
  logic        s1_valid_q;
  logic        s1_valid_d;
  ersw_reg_t   s1_reg_q;
  ersw_reg_t   s1_reg_d;
  logic [2:0]  s1_fault_q;
  logic [2:0]  s1_fault_d;
  logic        s1_range_q;
  logic        s1_range_d;
  logic [15:0] s1_sel_q;
  logic [15:0] s1_sel_d;
  logic        s1_write_q;
  logic        s1_write_d;
  logic              resp_valid_d;
  logic [DATA_W-1:0] resp_rdata_d;
  logic [2:0]        resp_fault_d;

  always_comb begin
    s1_valid_d = req_valid;
    s1_reg_d   = dec_reg;
    s1_fault_d = fault;
    s1_range_d = in_range;
    s1_sel_d   = select_q;
    s1_write_d = req_write;
  end

  always_comb begin
    resp_valid_d = s1_valid_q;
    resp_fault_d = s1_fault_q;
    resp_rdata_d = '0;
    // Writes answer zero, so never-written record words stay off the bus
    if (s1_valid_q && !s1_write_q && s1_fault_q == FLT_NONE) begin
      unique case (s1_reg_q)
        REG_COUNT:  resp_rdata_d = {16'h0000, REC_NUM};
        REG_SELECT: resp_rdata_d = {16'h0000, s1_sel_q};
        REG_ADR_LO: resp_rdata_d = s1_range_q ? adr_lo_rd : '0;
        REG_ADR_HI: resp_rdata_d = s1_range_q ? adr_hi_rd : '0;
        REG_CTL_LO: resp_rdata_d = s1_range_q ? ctl_lo_rd : '0;
        REG_NONE:   resp_rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_valid_q   <= 1'b0;
      s1_reg_q     <= REG_NONE;
      s1_fault_q   <= FLT_NONE;
      s1_range_q   <= 1'b0;
      s1_sel_q     <= 16'h0000;
      s1_write_q   <= 1'b0;
      resp_valid_q <= 1'b0;
      resp_rdata_q <= '0;
      resp_fault_q <= FLT_NONE;
    end else begin
      s1_valid_q   <= s1_valid_d;
      s1_reg_q     <= s1_reg_d;
      s1_fault_q   <= s1_fault_d;
      s1_range_q   <= s1_range_d;
      s1_sel_q     <= s1_sel_d;
      s1_write_q   <= s1_write_d;
      resp_valid_q <= resp_valid_d;
      resp_rdata_q <= resp_rdata_d;
      resp_fault_q <= resp_fault_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  app_undef_a: assert property (
    req_valid && ras_present && cur_level == LVL_APP |-> ##2 resp_valid_q && resp_fault_q == FLT_UNDEF)
    else $error("application level access not undefined");

  absent_undef_a: assert property (
    req_valid && !ras_present |-> ##2 resp_fault_q == FLT_UNDEF)
    else $error("access without extension not undefined");

  count_read_a: assert property (
    acc_ok && !req_write && dec_reg == REG_COUNT |-> ##2 resp_rdata_q == {16'h0000, REC_NUM})
    else $error("record count read wrong");

  count_write_a: assert property (
    req_valid && ras_present && cur_level != LVL_APP && req_write && dec_reg == REG_COUNT
    |-> ##2 resp_fault_q == FLT_UNDEF)
    else $error("count register write not undefined");

  hyp_route_a: assert property (
    req_valid && ras_present && dec_reg != REG_NONE && !(req_write && dec_reg == REG_COUNT)
    && hyp_present && hyp_wide && cur_level == LVL_KERNEL && !cur_secure
    && (hyp_err_trap || hyp_cp_group_trap) |-> ##2 resp_fault_q == FLT_TRAP_HYP)
    else $error("wide hypervisor trap missed");

  hyp_exc_a: assert property (
    req_valid && ras_present && dec_reg != REG_NONE && !(req_write && dec_reg == REG_COUNT)
    && hyp_present && !hyp_wide && cur_level == LVL_KERNEL && !cur_secure
    && (hyp_err_trap || hyp_cp_group_trap) |-> ##2 resp_fault_q == FLT_HYP_EXC)
    else $error("narrow hypervisor trap missed");

  mon_route_a: assert property (
    req_valid && ras_present && dec_reg != REG_NONE && !(req_write && dec_reg == REG_COUNT)
    && mon_present && mon_wide && mon_err_trap && cur_level == LVL_HYP
    |-> ##2 resp_fault_q == FLT_TRAP_MON)
    else $error("wide monitor trap missed");

  mon_exc_a: assert property (
    req_valid && ras_present && dec_reg != REG_NONE && !(req_write && dec_reg == REG_COUNT)
    && mon_present && !mon_wide && mon_err_trap && cur_level == LVL_HYP
    |-> ##2 resp_fault_q == FLT_MON_EXC)
    else $error("narrow monitor trap missed");

  sel_write_a: assert property (
    acc_ok && req_write && dec_reg == REG_SELECT |=> select_q == $past(req_wdata[15:0]))
    else $error("select write not stored");

  sequence lo_write_s;
    acc_ok && req_write && dec_reg == REG_ADR_LO && in_range;
  endsequence

  sequence lo_read_s;
    acc_ok && !req_write && dec_reg == REG_ADR_LO && $stable(select_q);
  endsequence

  property lo_roundtrip_p;
    lo_write_s ##1 lo_read_s |-> ##2 resp_rdata_q == $past(req_wdata, 3);
  endproperty

  window_rw_a: assert property (lo_roundtrip_p)
    else $error("windowed write not seen by next read");

  oor_raz_a: assert property (
    acc_ok && !req_write && dec_reg == REG_CTL_LO && !in_range |-> ##2 resp_rdata_q == '0)
    else $error("out of range window not zero");
endmodule

// ==== bench/ersw_tb.sv ====
// Self-checking testbench for the error record select window
`timescale 1ns/100ps
module tb;
  import ersw_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic              clk, rst_n, req_valid, req_write;
  logic [3:0]        req_cp, req_crn, req_crm;
  logic [2:0]        req_opc1, req_opc2;
  logic [DATA_W-1:0] req_wdata;
  logic [1:0]        cur_level;
  logic              cur_secure, ras_present, hyp_present, hyp_wide, hyp_err_trap, hyp_cp_group_trap;
  logic              mon_present, mon_wide, mon_err_trap, wide_sel_we;
  logic [15:0]       wide_sel_wdata;
  logic              resp_valid_q;
  logic [DATA_W-1:0] resp_rdata_q;
  logic [2:0]        resp_fault_q;
  logic [15:0]       select_q;
  int                errors, tests_run, cycles;
  localparam int     MAX_CYCLES = 2000;
  localparam logic [9:0] CFG_DEF = 10'b01_1_0000_000;
  // {level, secure, hyp present/wide/err/group, mon present/wide/err, fault}
  localparam logic [12:0] TRAPS [14] = '{
    {10'b00_1_0000_000, FLT_UNDEF},
    {10'b01_0_1110_000, FLT_TRAP_HYP},
    {10'b01_0_1101_000, FLT_TRAP_HYP},
    {10'b01_0_1010_000, FLT_HYP_EXC},
    {10'b01_0_1001_000, FLT_HYP_EXC},
    {10'b01_1_1111_000, FLT_NONE},
    {10'b10_0_1111_000, FLT_NONE},
    {10'b01_0_0111_000, FLT_NONE},
    {10'b10_0_0000_111, FLT_TRAP_MON},
    {10'b01_1_0000_111, FLT_TRAP_MON},
    {10'b11_1_0000_111, FLT_NONE},
    {10'b10_0_0000_101, FLT_MON_EXC},
    {10'b11_1_0000_101, FLT_NONE},
    {10'b01_0_0000_110, FLT_NONE}};

  ersw_top dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write), .req_cp(req_cp),
    .req_opc1(req_opc1), .req_crn(req_crn), .req_crm(req_crm), .req_opc2(req_opc2), .req_wdata(req_wdata),
    .cur_level(cur_level), .cur_secure(cur_secure), .ras_present(ras_present), .hyp_present(hyp_present),
    .hyp_wide(hyp_wide), .hyp_err_trap(hyp_err_trap), .hyp_cp_group_trap(hyp_cp_group_trap),
    .mon_present(mon_present), .mon_wide(mon_wide), .mon_err_trap(mon_err_trap), .wide_sel_we(wide_sel_we),
    .wide_sel_wdata(wide_sel_wdata), .resp_valid_q(resp_valid_q), .resp_rdata_q(resp_rdata_q),
    .resp_fault_q(resp_fault_q), .select_q(select_q));

  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // Access tasks and checks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cfg(input logic [9:0] c);
    {cur_level, cur_secure, hyp_present, hyp_wide, hyp_err_trap, hyp_cp_group_trap} = c[9:3];
    {mon_present, mon_wide, mon_err_trap} = c[2:0];
  endtask

  // One transfer: request held for one edge, answer checked two cycles on
  task automatic acc(input logic wr, input logic [3:0] crm, input logic [2:0] op2, input logic [31:0] wd,
                     input logic [31:0] ed, input logic [2:0] ef);
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_write = wr;
    req_crm   = crm;
    req_opc2  = op2;
    req_wdata = wd;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    chk("early answer", 32'h0, {31'h0, resp_valid_q});
    @(posedge clk);
    #1;
    chk("answer valid", 32'h1, {31'h0, resp_valid_q});
    chk("read data", ed, resp_rdata_q);
    chk("fault code", {29'h0, ef}, {29'h0, resp_fault_q});
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Guard against a missing answer hanging the run
  always @(posedge clk) begin
    cycles++;
    if (cycles == MAX_CYCLES) begin
      errors++;
      $display("Error run length expected below %0d seen %0d", MAX_CYCLES, cycles);
      wrap_up();
    end
  end

  initial begin
    {clk, rst_n, req_valid, req_write, ras_present, wide_sel_we} = 6'b000010;
    {req_cp, req_opc1, req_crn, req_crm, req_opc2} = {CP_NUM, OPC1_ERR, CRN_ERR, 4'h0, 3'h0};
    {req_wdata, wide_sel_wdata} = 48'h0;
    cfg(CFG_DEF);
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    acc(0, CRM_GLOBAL, OPC2_SELECT, 32'h0, {16'h0, SEL_RESET}, FLT_NONE);
    acc(0, CRM_GLOBAL, OPC2_COUNT, 32'h0, {16'h0, REC_NUM}, FLT_NONE);
    acc(1, CRM_GLOBAL, OPC2_COUNT, 32'h3, 32'h0, FLT_UNDEF);
    acc(0, CRM_GLOBAL, OPC2_COUNT, 32'h0, {16'h0, REC_NUM}, FLT_NONE);
    acc(1, CRM_GLOBAL, OPC2_SELECT, 32'hFFFF_0002, 32'h0, FLT_NONE);
    chk("select index", 32'h2, {16'h0, select_q});
    acc(0, CRM_GLOBAL, OPC2_SELECT, 32'h0, 32'h2, FLT_NONE);
    // Written in secure state, read back non-secure: one shared copy
    for (int i = 0; i < int'(REC_NUM); i++) begin
      acc(1, CRM_GLOBAL, OPC2_SELECT, 32'(i), 32'h0, FLT_NONE);
      acc(1, CRM_WINDOW, OPC2_ADR_LO, 32'hA5A5_0000 + 32'(i), 32'h0, FLT_NONE);
      acc(1, CRM_WINDOW, OPC2_ADR_HI, 32'h5A5A_0000 + 32'(i), 32'h0, FLT_NONE);
      acc(1, CRM_WINDOW, OPC2_CTL_LO, 32'hC3C3_0000 + 32'(i), 32'h0, FLT_NONE);
    end
    cfg(10'b01_0_0000_000);
    // Reverse order so a stuck or aliased index shows up
    for (int i = int'(REC_NUM) - 1; i >= 0; i--) begin
      acc(1, CRM_GLOBAL, OPC2_SELECT, 32'(i), 32'h0, FLT_NONE);
      acc(0, CRM_WINDOW, OPC2_ADR_LO, 32'h0, 32'hA5A5_0000 + 32'(i), FLT_NONE);
      acc(0, CRM_WINDOW, OPC2_ADR_HI, 32'h0, 32'h5A5A_0000 + 32'(i), FLT_NONE);
      acc(0, CRM_WINDOW, OPC2_CTL_LO, 32'h0, 32'hC3C3_0000 + 32'(i), FLT_NONE);
    end
    // Select write followed at once by a window read
    @(posedge clk);
    #1;
    {req_valid, req_write, req_crm, req_opc2, req_wdata} = {2'b11, CRM_GLOBAL, OPC2_SELECT, 32'h1};
    @(posedge clk);
    #1;
    {req_write, req_crm, req_opc2} = {1'b0, CRM_WINDOW, OPC2_ADR_LO};
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    chk("select answer", 32'h1, {31'h0, resp_valid_q});
    @(posedge clk);
    #1;
    chk("next cycle read", 32'hA5A5_0001, resp_rdata_q);
    acc(1, CRM_GLOBAL, OPC2_SELECT, {16'h0, REC_NUM}, 32'h0, FLT_NONE);
    acc(0, CRM_GLOBAL, OPC2_SELECT, 32'h0, {16'h0, REC_NUM}, FLT_NONE);
    acc(1, CRM_WINDOW, OPC2_ADR_LO, 32'h1234_5678, 32'h0, FLT_NONE);
    acc(0, CRM_WINDOW, OPC2_ADR_LO, 32'h0, 32'h0, FLT_NONE);
    acc(0, CRM_WINDOW, OPC2_CTL_LO, 32'h0, 32'h0, FLT_NONE);
    @(posedge clk);
    #1;
    {wide_sel_we, wide_sel_wdata} = {1'b1, 16'h0003};
    @(posedge clk);
    #1;
    wide_sel_we = 1'b0;
    acc(0, CRM_GLOBAL, OPC2_SELECT, 32'h0, 32'h3, FLT_NONE);
    foreach (TRAPS[k]) begin
      cfg(TRAPS[k][12:3]);
      acc(0, CRM_GLOBAL, OPC2_COUNT, 32'h0, (TRAPS[k][2:0] == FLT_NONE) ? {16'h0, REC_NUM} : 32'h0,
          TRAPS[k][2:0]);
    end
    // A trapped write must leave the record untouched
    cfg(10'b01_0_1110_000);
    acc(1, CRM_WINDOW, OPC2_ADR_LO, 32'hFFFF_FFFF, 32'h0, FLT_TRAP_HYP);
    cfg(CFG_DEF);
    acc(0, CRM_WINDOW, OPC2_ADR_LO, 32'h0, 32'hA5A5_0003, FLT_NONE);
    // Window write then read of the same record in the very next cycle
    @(posedge clk);
    #1;
    {req_valid, req_write, req_crm, req_opc2, req_wdata} = {2'b11, CRM_WINDOW, OPC2_ADR_LO, 32'h1357_9BDF};
    @(posedge clk);
    #1;
    req_write = 1'b0;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    chk("write answer", 32'h0, resp_rdata_q);
    @(posedge clk);
    #1;
    chk("back to back read", 32'h1357_9BDF, resp_rdata_q);
    ras_present = 1'b0;
    acc(0, CRM_GLOBAL, OPC2_SELECT, 32'h0, 32'h0, FLT_UNDEF);
    acc(1, CRM_WINDOW, OPC2_ADR_HI, 32'h0, 32'h0, FLT_UNDEF);
    ras_present = 1'b1;
    req_cp = 4'hE;
    acc(0, CRM_GLOBAL, OPC2_COUNT, 32'h0, 32'h0, FLT_UNDEF);
    req_cp = CP_NUM;
    acc(0, CRM_GLOBAL, OPC2_SELECT, 32'h0, 32'h3, FLT_NONE);
    wrap_up();
  end
endmodule
